// File: psm_pkg.sv
// Package for the pin state / power mode control block.
// Assumes one system clock and an Avalon-MM register master.
`default_nettype none
package psm_pkg;
    localparam int NPINS = 8;
    localparam int AW = 5;
    // Power states, one-hot
    typedef enum logic [6:0] {
        ST_POR = 7'h01,
        ST_XRST = 7'h02,
        ST_IRST = 7'h04,
        ST_RUN = 7'h08,
        ST_STBY = 7'h10,
        ST_DSTBY = 7'h20,
        ST_DRET = 7'h40
    } psm_state_e;
    // Pin function codes, three bits per pin
    typedef enum logic [2:0] {
        FN_GPIO = 3'h0,
        FN_PERIPH = 3'h1,
        FN_EXTINT = 3'h2,
        FN_WAKEUP = 3'h3,
        FN_ANALOG = 3'h4,
        FN_OSC_OUT = 3'h5,
        FN_CLK_IN = 3'h6
    } psm_func_e;
    // Register byte offsets
    localparam logic [AW-1:0] OFS_CTRL = 5'h00;
    localparam logic [AW-1:0] OFS_FUNC = 5'h04;
    localparam logic [AW-1:0] OFS_PORT_OUT = 5'h08;
    localparam logic [AW-1:0] OFS_PORT_DIR = 5'h0c;
    localparam logic [AW-1:0] OFS_STATUS = 5'h10;
    localparam logic [AW-1:0] OFS_PIN_IN = 5'h14;
    // Field positions
    localparam int CTRL_SPL_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_FORCED_LSB = 8;
    localparam int FUNC_W = 3;
    // Reset values
    localparam logic CTRL_SPL_RST = 1'b0;
    localparam logic [23:0] FUNC_RST = 24'h000000;
    localparam logic [7:0] PORT_OUT_RST = 8'h00;
    localparam logic [7:0] PORT_DIR_RST = 8'h00;
endpackage
`default_nettype wire

// File: psm_pin_ctrl.sv
// Pin state control across reset, run, standby and deep standby states.
// Assumes a power-mode controller driving the state request inputs and
// an Avalon-MM master on the register port, all on i_clk_sys.
//
// Notes on behaviour
// - Standby level bit: keep pins, or float GPIO
// - Unusable input presents constant low internally
// - High impedance turns output driver fully off
// - Held state keeps condition before mode entry
// - Held peripheral pin tracks the peripheral output
// - Held port pin keeps last port value
// - Deep standby switches ordinary pins to port
// - Function settings ignored during reset states
// - Reset pin keeps pull-up and input always
// - Power-on reset floats all pins, settings unapplied
// - External and internal reset: float, input on
// - Run and sleep apply no standby gating
// - Oscillator output floats, input low when stopped
// - Clock input floats in standby, low if stopped
// - Deep standby, bit clear: drive, input low
// - Analog pin: driver off, digital input low
// - Wake-up pin keeps wake input in deep
// - Interrupt pin functional in standby, port in deep
// - Peripheral pins float in standby when bit set
// - After deep return, port control until reconfigured
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module psm_pin_ctrl (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Power-mode controller
    input wire logic i_por,
    input wire logic i_external_reset_input,
    input wire logic i_int_rst,
    input wire logic i_stby_req,
    input wire logic i_dstby_req,
    input wire logic i_wake,
    input wire logic i_osc_stop,
    // Peripheral side
    input wire logic [psm_pkg::NPINS-1:0] i_periph_out,
    input wire logic [psm_pkg::NPINS-1:0] i_periph_oe,
    // Pads
    input wire logic [psm_pkg::NPINS-1:0] i_pin_in,
    output logic [psm_pkg::NPINS-1:0] o_pin_out,
    output logic [psm_pkg::NPINS-1:0] o_pin_oe,
    output logic [psm_pkg::NPINS-1:0] o_pin_ien,
    output logic [psm_pkg::NPINS-1:0] o_int_in,
    output logic [psm_pkg::NPINS-1:0] o_wakeup_input,
    output logic [psm_pkg::NPINS-1:0] o_analog_en,
    output logic o_rst_pullup_en,
    output logic o_rst_in_en,
    // Avalon-MM slave
    input wire logic [psm_pkg::AW-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest
);
    import psm_pkg::*;

    typedef struct packed {
        psm_state_e state;
        logic standby_pin_level_select;
        logic [23:0] func;
        logic [NPINS-1:0] port_out;
        logic [NPINS-1:0] port_dir;
        logic [NPINS-1:0] forced;
        logic [NPINS-1:0] held_out;
        logic [NPINS-1:0] held_oe;
        logic [NPINS-1:0] held_ien;
        logic [NPINS-1:0] pin_out;
        logic [NPINS-1:0] pin_oe;
        logic [NPINS-1:0] pin_ien;
        logic [NPINS-1:0] int_in;
        logic [NPINS-1:0] wake_en;
        logic [NPINS-1:0] ana_en;
        logic ack;
        logic [31:0] rdata;
    } psm_regs_s;

    localparam psm_regs_s RST_S = '{
        state: ST_POR, standby_pin_level_select: CTRL_SPL_RST, func: FUNC_RST,
        port_out: PORT_OUT_RST, port_dir: PORT_DIR_RST,
        default: '0};

    psm_regs_s s;
    psm_regs_s next_s;

    function automatic psm_func_e pin_func(input logic [23:0] f,
                                           input int i);
        logic [2:0] c;
        c = f[i*FUNC_W +: FUNC_W];
        return psm_func_e'(c);
    endfunction

    function automatic logic is_reset_st(input psm_state_e st);
        return (st == ST_POR) || (st == ST_XRST) || (st == ST_IRST);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus: one wait cycle on every access, then answer
    logic req;
    logic wr_go;
    logic func_wr;
    assign req = i_read | i_write;
    assign o_waitrequest = req & ~s.ack;
    assign wr_go = i_write & s.ack;
    assign func_wr = wr_go && (i_address == OFS_FUNC) &&
        !is_reset_st(s.state);

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        psm_func_e fn;
        logic oe;
        logic out;
        logic ien;
        logic wk;
        logic ana;
        logic track;
        fn = FN_GPIO;
        oe = 1'b0;
        out = 1'b0;
        ien = 1'b0;
        wk = 1'b0;
        ana = 1'b0;
        track = 1'b0;
        next_s = s;
        next_s.ack = req & ~s.ack;
        if (req && !s.ack) begin
            case (i_address)
                OFS_CTRL: next_s.rdata = {31'h0, s.standby_pin_level_select};
                OFS_FUNC: next_s.rdata = {8'h00, s.func};
                OFS_PORT_OUT: next_s.rdata = {24'h0, s.port_out};
                OFS_PORT_DIR: next_s.rdata = {24'h0, s.port_dir};
                OFS_STATUS: next_s.rdata = {16'h0, s.forced, 1'b0, s.state};
                OFS_PIN_IN: next_s.rdata = {24'h0, s.int_in};
                default: next_s.rdata = 32'h0;
            endcase
        end
        // Writes during reset states are dropped
        if (wr_go && !is_reset_st(s.state)) begin
            case (i_address)
                OFS_CTRL: next_s.standby_pin_level_select = i_writedata[CTRL_SPL_BIT];
                OFS_FUNC: next_s.func = i_writedata[23:0];
                OFS_PORT_OUT: next_s.port_out = i_writedata[NPINS-1:0];
                OFS_PORT_DIR: next_s.port_dir = i_writedata[NPINS-1:0];
                default: ;
            endcase
        end
        // Power state sequencing
        if (i_por) begin
            next_s.state = ST_POR;
        end else if (!i_external_reset_input) begin
            next_s.state = ST_XRST;
        end else if (i_int_rst) begin
            next_s.state = ST_IRST;
        end else begin
            case (s.state)
                ST_POR, ST_XRST, ST_IRST: next_s.state = ST_RUN;
                ST_RUN: begin
                    if (i_dstby_req) begin
                        next_s.state = ST_DSTBY;
                    end else if (i_stby_req) begin
                        next_s.state = ST_STBY;
                    end
                end
                ST_STBY: begin
                    if (!i_stby_req) begin
                        next_s.state = ST_RUN;
                    end
                end
                ST_DSTBY: begin
                    if (i_wake) begin
                        next_s.state = ST_DRET;
                    end
                end
                ST_DRET: begin
                    if (func_wr) begin
                        next_s.state = ST_RUN;
                    end
                end
                default: next_s.state = ST_POR;
            endcase
        end
        // Configuration is not kept through a device reset
        if (is_reset_st(next_s.state)) begin
            next_s.standby_pin_level_select = CTRL_SPL_RST;
            next_s.func = FUNC_RST;
            next_s.port_out = PORT_OUT_RST;
            next_s.port_dir = PORT_DIR_RST;
            next_s.forced = '0;
        end
        // Snapshot on entry so held pins see the pre-entry condition
        if ((next_s.state == ST_STBY || next_s.state == ST_DSTBY) &&
            s.state != next_s.state) begin
            next_s.held_out = s.pin_out;
            next_s.held_oe = s.pin_oe;
            next_s.held_ien = s.pin_ien;
        end
        if (func_wr) begin
            next_s.forced = '0;
        end
        for (int i = 0; i < NPINS; i++) begin
            fn = pin_func(next_s.func, i);
            if (next_s.state == ST_DSTBY && s.state != ST_DSTBY &&
                fn != FN_WAKEUP && fn != FN_ANALOG && fn != FN_OSC_OUT) begin
                next_s.forced[i] = 1'b1;
            end
            // Run-state values from the selected function
            wk = 1'b0;
            ana = 1'b0;
            track = 1'b0;
            case (fn)
                FN_GPIO: begin
                    oe = next_s.port_dir[i];
                    out = next_s.port_out[i];
                    ien = 1'b1;
                end
                FN_PERIPH, FN_WAKEUP: begin
                    oe = i_periph_oe[i];
                    out = i_periph_out[i];
                    ien = 1'b1;
                    track = 1'b1;
                end
                FN_EXTINT: begin
                    oe = 1'b0;
                    out = 1'b0;
                    ien = 1'b1;
                    track = 1'b1;
                end
                FN_OSC_OUT: begin
                    oe = ~i_osc_stop;
                    out = i_periph_out[i];
                    ien = ~i_osc_stop;
                    track = 1'b1;
                end
                FN_CLK_IN: begin
                    oe = 1'b0;
                    out = 1'b0;
                    ien = ~i_osc_stop;
                end
                default: begin
                    oe = 1'b0;
                    out = 1'b0;
                    ien = 1'b0;
                end
            endcase
            if (next_s.forced[i]) begin
                oe = next_s.port_dir[i];
                out = next_s.port_out[i];
                ien = 1'b1;
                track = 1'b0;
            end
            case (next_s.state)
                ST_POR: begin
                    oe = 1'b0;
                    ien = 1'b0;
                end
                ST_XRST, ST_IRST: begin
                    oe = 1'b0;
                    ien = (fn != FN_OSC_OUT);
                end
                ST_RUN, ST_DRET: ;
                ST_STBY: begin
                    // Peripheral keeps driving; port keeps last value
                    oe = next_s.held_oe[i];
                    out = track ? i_periph_out[i] : next_s.held_out[i];
                    ien = next_s.held_ien[i];
                    case (fn)
                        FN_GPIO, FN_PERIPH, FN_WAKEUP: begin
                            if (next_s.standby_pin_level_select) begin
                                oe = 1'b0;
                                ien = 1'b0;
                            end
                        end
                        FN_EXTINT: ien = 1'b1;
                        FN_OSC_OUT: begin
                            if (i_osc_stop) begin
                                oe = 1'b0;
                                ien = 1'b0;
                            end
                        end
                        FN_CLK_IN: begin
                            if (next_s.standby_pin_level_select) begin
                                oe = 1'b0;
                                ien = 1'b1;
                            end
                            if (i_osc_stop) begin
                                ien = 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
                ST_DSTBY: begin
                    ien = 1'b0;
                    if (next_s.forced[i]) begin
                        oe = next_s.standby_pin_level_select ? 1'b0 : next_s.port_dir[i];
                        out = next_s.port_out[i];
                    end else if (fn == FN_WAKEUP) begin
                        wk = 1'b1;
                        oe = next_s.standby_pin_level_select ? 1'b0 : next_s.held_oe[i];
                        out = next_s.held_out[i];
                    end else if (fn == FN_OSC_OUT) begin
                        oe = i_osc_stop ? 1'b0 : next_s.held_oe[i];
                        out = i_periph_out[i];
                    end
                end
                default: begin
                    oe = 1'b0;
                    ien = 1'b0;
                end
            endcase
            if (fn == FN_ANALOG && !next_s.forced[i]) begin
                oe = 1'b0;
                ien = 1'b0;
                ana = 1'b1;
            end
            if (next_s.state == ST_POR) begin
                ana = 1'b0;
            end
            next_s.pin_oe[i] = oe;
            next_s.pin_out[i] = oe & out;
            next_s.pin_ien[i] = ien;
            next_s.int_in[i] = ien & i_pin_in[i];
            next_s.wake_en[i] = wk;
            next_s.ana_en[i] = ana;
        end
        if (!i_rst_n) begin
            next_s = RST_S;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////
    assign o_pin_out = s.pin_out;
    assign o_pin_oe = s.pin_oe;
    assign o_pin_ien = s.pin_ien;
    assign o_int_in = s.int_in;
    assign o_wakeup_input = s.wake_en & i_pin_in;
    assign o_analog_en = s.ana_en;
    // Reset pad is never gated by any state
    assign o_rst_pullup_en = 1'b1;
    assign o_rst_in_en = 1'b1;
    assign o_readdata = s.rdata;

    ////////////////////////////////////////////////////////////////////
    // Helper masks for checks
    logic [NPINS-1:0] gpio_mask;
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            gpio_mask[i] = (pin_func(s.func, i) == FN_GPIO);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_pullup_always: assert property (o_rst_pullup_en && o_rst_in_en)
        else $error("reset pin pull-up or input dropped");
    a_unusable_low: assert property ((o_int_in & ~o_pin_ien) == '0)
        else $error("gated input not low");
    a_hiz_no_drive: assert property ((o_pin_out & ~o_pin_oe) == '0)
        else $error("pin value present while floated");
    a_analog_off: assert property (
        (o_analog_en & (o_pin_oe | o_pin_ien)) == '0)
        else $error("analog pin has digital path on");
    a_por_float: assert property ($past(i_por) |->
        o_pin_oe == '0 && o_int_in == '0)
        else $error("pins not floated in power-on reset");
    a_xrst_float: assert property (!i_por &&
        !i_external_reset_input |=> o_pin_oe == '0 && s.state == ST_XRST)
        else $error("pins not floated in external reset");
    a_stby_gpio_float: assert property (s.state == ST_STBY &&
        s.standby_pin_level_select |-> (o_pin_oe & gpio_mask) == '0)
        else $error("GPIO driven in standby with level bit set");
    a_deep_forced: assert property (s.state == ST_RUN &&
        !i_por && i_external_reset_input && !i_int_rst &&
        i_dstby_req |=> s.state == ST_DSTBY &&
        (s.forced & gpio_mask) == gpio_mask)
        else $error("GPIO not forced to port in deep standby");
    a_dret_forced_keep: assert property (s.state == ST_DRET &&
        !func_wr && !i_por && i_external_reset_input && !i_int_rst |=>
        s.forced == $past(s.forced))
        else $error("forced port control lost after deep return");
    a_bus_answer: assert property (req && !o_waitrequest |-> $past(req))
        else $error("answer without wait cycle");

    c_standby: cover property (s.state == ST_RUN ##1 s.state == ST_STBY);
    c_deep: cover property (s.state == ST_DSTBY ##1 s.state == ST_DRET);
    c_dret_run: cover property (s.state == ST_DRET ##1 s.state == ST_RUN);
endmodule
`default_nettype wire

// File: psm_board.sv
// Board model: a pull-up resistor on every device pad.
// Assumes the pad driver and enable outputs of the pin control block.
`timescale 1ns/100ps
`default_nettype none
module psm_board #(
    parameter logic PULL_LEVEL = 1'b1
) (
    // Device pad drivers
    input wire logic [psm_pkg::NPINS-1:0] i_pin_out,
    input wire logic [psm_pkg::NPINS-1:0] i_pin_oe,
    // Resolved pad levels
    output logic [psm_pkg::NPINS-1:0] o_pad
);
    import psm_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Released pad falls to the resistor, never a stale level
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            o_pad[i] = i_pin_oe[i] ? i_pin_out[i] : PULL_LEVEL;
        end
    end
endmodule
`default_nettype wire

// File: test_pin_state_power_mode_control.sv
// Testbench for the pin state control block.
// Assumes the board model and the register offsets of the package.
`timescale 1ns/100ps
`default_nettype none
module test_pin_state_power_mode_control;
    import psm_pkg::*;
    typedef struct packed {
        logic standby_pin_level_select;
        logic osc;
        logic [7:0] pout;
        logic [1:0] mode;
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] ien;
        logic [7:0] msk;
    } psm_row_s;
    // Pin i uses function code i, pin 7 is a port pin
    localparam logic [31:0] FUNC_CFG = 32'h001ac688;
    logic clk = 1'b0;
    logic rst_n, por, xrst, irst, stby, dstby, wake, osc, rd, wr, waitreq;
    logic pu_en, in_en;
    logic [7:0] pout, poe, pad, o_out, o_oe, o_ien, o_int, o_wk, o_an;
    logic [4:0] addr;
    logic [31:0] wdat, rdat;
    int failures = 0;
    int num_checks = 0;
    psm_row_s rows [7];
    ////////////////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    psm_pin_ctrl dut_u (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_por(por),
        .i_external_reset_input(xrst), .i_int_rst(irst),
        .i_stby_req(stby), .i_dstby_req(dstby), .i_wake(wake),
        .i_osc_stop(osc), .i_periph_out(pout), .i_periph_oe(poe),
        .i_pin_in(pad), .o_pin_out(o_out), .o_pin_oe(o_oe),
        .o_pin_ien(o_ien), .o_int_in(o_int), .o_wakeup_input(o_wk),
        .o_analog_en(o_an), .o_rst_pullup_en(pu_en), .o_rst_in_en(in_en),
        .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdat),
        .o_readdata(rdat), .o_waitrequest(waitreq)
    );
    psm_board board_u (.i_pin_out(o_out), .i_pin_oe(o_oe), .o_pad(pad));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
            input logic [7:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("BAD %0t got %h want %h mask %h", $time, got, exp, m);
        end
    endtask
    // Slave answers after one wait cycle; no count is assumed here
    task automatic bus_go(input logic [4:0] a, input logic [31:0] d,
            input logic is_rd, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdat <= d;
        rd <= is_rd;
        wr <= ~is_rd;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        if (n >= 100) begin
            failures++;
            $display("BAD %0t bus answer timed out", $time);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_go(a, d, 1'b0, q);
    endtask
    task automatic bus_rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_go(a, 32'h0, 1'b1, q);
        num_checks++;
        if (q !== exp) begin
            failures++;
            $display("BAD %0t read %h got %h want %h", $time, a, q, exp);
        end
    endtask
    task automatic settle_chk_rst(input logic [7:0] ien);
        @(posedge clk);
        #1;
        chk8(o_oe, 8'h00, 8'hff);
        chk8(o_ien, ien, 8'hff);
        chk8({6'h0, pu_en, in_en}, 8'h03, 8'hff);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        rst_n = 1'b0; por = 1'b0; xrst = 1'b1; irst = 1'b0; stby = 1'b0;
        dstby = 1'b0; wake = 1'b0; osc = 1'b0; rd = 1'b0; wr = 1'b0;
        pout = 8'h02; poe = 8'h02; addr = 5'h00; wdat = 32'h0;
        // spl osc pout mode oe out ien mask
        rows[0] = '{1'b0, 1'b0, 8'h02, 2'd0, 8'h83, 8'h03, 8'hcf, 8'hd7};
        rows[1] = '{1'b0, 1'b0, 8'h00, 2'd1, 8'h83, 8'h01, 8'hcf, 8'hd7};
        rows[2] = '{1'b1, 1'b0, 8'h02, 2'd1, 8'h00, 8'h00, 8'h44, 8'hdf};
        rows[3] = '{1'b1, 1'b1, 8'h02, 2'd1, 8'h00, 8'h00, 8'h04, 8'hff};
        rows[4] = '{1'b0, 1'b0, 8'h02, 2'd2, 8'h81, 8'h01, 8'h00, 8'hd7};
        rows[5] = '{1'b1, 1'b1, 8'h02, 2'd2, 8'h00, 8'h00, 8'h00, 8'hf7};
        rows[6] = '{1'b1, 1'b1, 8'h02, 2'd0, 8'h83, 8'h03, 8'hcf, 8'hb7};
        // Rows
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        bus_rd(OFS_CTRL, 32'h0);
        bus_rd(OFS_FUNC, 32'h0);
        bus_rd(OFS_PORT_OUT, 32'h0);
        bus_rd(OFS_PORT_DIR, 32'h0);
        bus_rd(OFS_PIN_IN, 32'hff);
        bus_wr(OFS_STATUS, 32'hffff);
        bus_rd(OFS_STATUS, 32'h8);
        bus_rd(5'h18, 32'h0);
        bus_wr(OFS_PORT_DIR, 32'h81);
        bus_wr(OFS_PORT_OUT, 32'h01);
        bus_wr(OFS_FUNC, FUNC_CFG);
        foreach (rows[k]) begin
            bus_wr(OFS_CTRL, {31'h0, rows[k].standby_pin_level_select});
            @(posedge clk);
            osc <= rows[k].osc;
            pout <= rows[k].pout;
            stby <= (rows[k].mode == 2'd1);
            dstby <= (rows[k].mode == 2'd2);
            @(posedge clk);
            dstby <= 1'b0;
            #1;
            chk8(o_oe, rows[k].oe, rows[k].msk);
            chk8(o_out, rows[k].out, rows[k].msk);
            chk8(o_ien, rows[k].ien, rows[k].msk);
            chk8(o_an, 8'h10, 8'hff);
            @(posedge clk);
            #1;
            chk8(o_int, rows[k].ien & (rows[k].out | ~rows[k].oe),
                rows[k].msk);
            if (rows[k].mode == 2'd2) begin
                chk8(o_wk, 8'h08, 8'hff);
                bus_rd(OFS_STATUS, 32'h0000c720);
                @(posedge clk);
                wake <= 1'b1;
                @(posedge clk);
                wake <= 1'b0;
                @(posedge clk);
                #1;
                chk8(o_oe, 8'h81, 8'hd7);
                bus_wr(OFS_FUNC, FUNC_CFG);
                @(posedge clk);
                #1;
                chk8(o_oe, 8'h02, 8'h02);
            end
            @(posedge clk);
            stby <= 1'b0;
        end
        // Reset states: config cleared, writes dropped
        @(posedge clk);
        osc <= 1'b0;
        xrst <= 1'b0;
        settle_chk_rst(8'hff);
        bus_wr(OFS_FUNC, 32'h249);
        @(posedge clk);
        xrst <= 1'b1;
        bus_rd(OFS_FUNC, 32'h0);
        bus_wr(OFS_PORT_DIR, 32'hff);
        @(posedge clk);
        irst <= 1'b1;
        #1;
        chk8(o_oe, 8'hff, 8'hff);
        settle_chk_rst(8'hff);
        @(posedge clk);
        irst <= 1'b0;
        @(posedge clk);
        por <= 1'b1;
        settle_chk_rst(8'h00);
        bus_rd(OFS_STATUS, 32'h1);
        @(posedge clk);
        por <= 1'b0;
        rst_n <= 1'b0;
        settle_chk_rst(8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        bus_rd(OFS_PORT_DIR, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
